// File: hw/card_host_defines.svh
// timing counts and fixed addresses for the card socket write controller
`ifndef CARD_HOST_DEFINES_SVH
`define CARD_HOST_DEFINES_SVH

`define CLK_PERIOD_NS 20
`define ADDR_SETUP_NS 30
`define ADDR_SETUP_CYC ((`ADDR_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WE_PULSE_NS 150
`define WE_PULSE_CYC ((`WE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WE_RECOVERY_NS 30
`define WE_RECOVERY_CYC ((`WE_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_PULSE_NS 10000
`define RESET_PULSE_CYC ((`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READY_WAIT_NS 2000
`define READY_WAIT_CYC ((`READY_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONFIG_OPTION_ADDR 11'h200
`define SOFT_RESET_BIT 7

`endif

// File: hw/card_host_pkg.sv
// types shared by the card socket write controller
package card_host_pkg;

   typedef enum logic [1:0] {
      MODE_MEMORY = 2'h0,
      MODE_IO = 2'h1,
      MODE_DIRECT_ATA = 2'h2
   } mode_e;

   typedef enum logic [5:0] {
      ST_RESET = 6'h01,
      ST_READY_WAIT = 6'h02,
      ST_IDLE = 6'h04,
      ST_SETUP = 6'h08,
      ST_STROBE = 6'h10,
      ST_RECOVER = 6'h20
   } state_e;

   // levels sampled from the card connector
   typedef struct packed {
      logic waitN;
      logic rdy;
      logic wpPin;
      logic vs1N;
      logic vs2N;
   } pin_in_s;

   // decoded meaning of the card status pins
   typedef struct packed {
      logic cardReady;
      logic writeProtect;
      logic port16;
      logic word16;
      logic lowVoltCis;
      logic secondSenseOpen;
   } status_s;

endpackage

// File: hw/card_host_port.sv
// host-side controller for the card control pins: reset, write strobe, wait, status
// Summary of operation
// (RULE_01) memory and I/O modes: card reset pin is driven high to reset.
// (RULE_02) card reset pin held high from power-up gives only a power-up reset.
// (RULE_03) soft reset: host writes the soft reset bit in the option register.
// (RULE_04) direct ATA mode: card reset pin is active low.
// (RULE_05) write strobe stays low while the card holds wait low.
// (RULE_06) direct ATA mode: wait line serves as IORDY.
// (RULE_07) memory mode: strobe writes both common memory and configuration registers.
// (RULE_08) I/O mode: strobe writes configuration registers only.
// (RULE_09) direct ATA mode: write strobe is tied high and never pulsed.
// (RULE_10) memory mode: write-protect pin reads low after reset completes.
// (RULE_11) I/O mode: same pin low means 16-bit or odd-byte port.
// (RULE_12) direct ATA mode: same pin low means a word transfer is expected.
// (RULE_13) first voltage-sense pin grounded, second open, in every mode.
// (RULE_14) no access while the card is busy after power-up or reset.
// (RULE_15) pin meanings follow the mode, which changes only between accesses.
`timescale 1ns/1ns
`include "card_host_defines.svh"

module card_host_port #(
   parameter int ADDR_W = 11,
   parameter int DATA_W = 16,
   parameter int CNT_W = 16
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire card_host_pkg::mode_e mode,
   input wire logic hwResetReq,
   input wire logic softResetReq,
   input wire logic wrReq,
   input wire logic wrAttr,
   input wire logic [ADDR_W-1:0] wrAddr,
   input wire logic [DATA_W-1:0] wrData,
   output logic reqReady,
   output logic wrDone,
   output logic resetBusy,
   output card_host_pkg::status_s status,
   output logic cardResetPin,
   output logic cardCeN,
   output logic cardRegN,
   output logic cardWeN,
   output logic [ADDR_W-1:0] cardAddr,
   output logic [DATA_W-1:0] cardDataOut,
   output logic cardDataOeN,
   input wire card_host_pkg::pin_in_s cardPins
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      card_host_pkg::state_e st;
      card_host_pkg::mode_e mode;
      logic [CNT_W-1:0] cnt;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic attr;
      logic softPhase;
      logic resetActive;
      logic done;
      logic resetPin;
      logic ceN;
      logic regN;
      logic weN;
      logic dataOeN;
      card_host_pkg::pin_in_s s1;
      card_host_pkg::pin_in_s s2;
      card_host_pkg::status_s stat;
   } regs_s;

   localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(`ADDR_SETUP_CYC - 1);
   localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(`WE_PULSE_CYC - 1);
   localparam logic [CNT_W-1:0] RECOVER_LAST = CNT_W'(`WE_RECOVERY_CYC - 1);
   localparam logic [CNT_W-1:0] RESET_LAST = CNT_W'(`RESET_PULSE_CYC - 1);
   localparam logic [CNT_W-1:0] READY_LAST = CNT_W'(`READY_WAIT_CYC - 1);
   localparam logic [ADDR_W-1:0] OPTION_ADDR = ADDR_W'(`CONFIG_OPTION_ADDR);
   localparam logic [DATA_W-1:0] SOFT_SET = DATA_W'(1) << `SOFT_RESET_BIT;

   regs_s r;
   regs_s next_r;
   logic rstMeta;
   logic rstSync;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // which writes the strobe may carry in a given mode
   function automatic logic writeAllowed(input card_host_pkg::mode_e m, input logic attr);
      case (m)
         card_host_pkg::MODE_MEMORY: writeAllowed = 1'b1; // [RULE_07]
         card_host_pkg::MODE_IO: writeAllowed = attr; // [RULE_08]
         default: writeAllowed = 1'b0; // [RULE_09]
      endcase
   endfunction

   // decode the shared status pins by mode
   function automatic card_host_pkg::status_s decodeStatus(input card_host_pkg::mode_e m,
                                                          input card_host_pkg::pin_in_s p,
                                                          input logic idle);
      card_host_pkg::status_s s;
      s = '0;
      s.cardReady = idle;
      s.writeProtect = (m == card_host_pkg::MODE_MEMORY) && p.wpPin; // [RULE_10]
      s.port16 = (m == card_host_pkg::MODE_IO) && !p.wpPin; // [RULE_11]
      s.word16 = (m == card_host_pkg::MODE_DIRECT_ATA) && !p.wpPin; // [RULE_12]
      s.lowVoltCis = !p.vs1N; // [RULE_13]
      s.secondSenseOpen = p.vs2N; // [RULE_13]
      decodeStatus = s;
   endfunction

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else if (clkEn) begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic active;
      active = 1'b0;
      next_r = r;
      next_r.s1 = cardPins;
      next_r.s2 = r.s1;
      next_r.done = 1'b0;
      case (r.st)
         card_host_pkg::ST_RESET: begin
            next_r.resetActive = 1'b1;
            if (r.cnt == '0) begin
               next_r.resetActive = 1'b0;
               next_r.cnt = READY_LAST;
               next_r.st = card_host_pkg::ST_READY_WAIT;
            end else begin
               next_r.cnt = r.cnt - CNT_W'(1);
            end
         end
         card_host_pkg::ST_READY_WAIT: begin
            // only memory mode has a busy pin; other modes wait a fixed time
            if (r.mode == card_host_pkg::MODE_MEMORY) begin
               if (r.s2.rdy) begin
                  next_r.st = card_host_pkg::ST_IDLE; // [RULE_14]
               end
            end else if (r.cnt == '0) begin
               next_r.st = card_host_pkg::ST_IDLE; // [RULE_14]
            end else begin
               next_r.cnt = r.cnt - CNT_W'(1);
            end
         end
         card_host_pkg::ST_IDLE: begin
            next_r.mode = mode; // [RULE_15]
            if (hwResetReq) begin
               next_r.cnt = RESET_LAST;
               next_r.st = card_host_pkg::ST_RESET;
            end else if (softResetReq && mode != card_host_pkg::MODE_DIRECT_ATA) begin
               next_r.addr = OPTION_ADDR; // [RULE_03]
               next_r.data = SOFT_SET;
               next_r.attr = 1'b1;
               next_r.softPhase = 1'b1;
               next_r.cnt = SETUP_LAST;
               next_r.st = card_host_pkg::ST_SETUP;
            end else if (wrReq && writeAllowed(mode, wrAttr)) begin
               next_r.addr = wrAddr;
               next_r.data = wrData;
               next_r.attr = wrAttr;
               next_r.cnt = SETUP_LAST;
               next_r.st = card_host_pkg::ST_SETUP;
            end
         end
         card_host_pkg::ST_SETUP: begin
            if (r.cnt == '0) begin
               next_r.cnt = PULSE_LAST;
               next_r.st = card_host_pkg::ST_STROBE;
            end else begin
               next_r.cnt = r.cnt - CNT_W'(1);
            end
         end
         card_host_pkg::ST_STROBE: begin
            if (r.cnt != '0) begin
               next_r.cnt = r.cnt - CNT_W'(1);
            end else if (r.s2.waitN) begin
               next_r.cnt = RECOVER_LAST; // [RULE_05] [RULE_06]
               next_r.st = card_host_pkg::ST_RECOVER;
            end
         end
         card_host_pkg::ST_RECOVER: begin
            if (r.cnt != '0) begin
               next_r.cnt = r.cnt - CNT_W'(1);
            end else if (r.softPhase && r.data != '0) begin
               // second write releases the soft reset bit again
               next_r.data = '0; // [RULE_03]
               next_r.cnt = SETUP_LAST;
               next_r.st = card_host_pkg::ST_SETUP;
            end else if (r.softPhase) begin
               next_r.softPhase = 1'b0;
               next_r.cnt = READY_LAST;
               next_r.st = card_host_pkg::ST_READY_WAIT; // [RULE_14]
            end else begin
               next_r.done = 1'b1;
               next_r.st = card_host_pkg::ST_IDLE;
            end
         end
         default: begin
            next_r.cnt = RESET_LAST;
            next_r.st = card_host_pkg::ST_RESET;
         end
      endcase
      active = (next_r.st == card_host_pkg::ST_SETUP) ||
               (next_r.st == card_host_pkg::ST_STROBE) ||
               (next_r.st == card_host_pkg::ST_RECOVER);
      // active high in card modes, active low in direct ATA mode
      next_r.resetPin = next_r.resetActive ^
                        (next_r.mode == card_host_pkg::MODE_DIRECT_ATA); // [RULE_01] [RULE_04]
      next_r.ceN = !active;
      next_r.regN = !(active && next_r.attr);
      next_r.dataOeN = !active;
      next_r.weN = (next_r.st != card_host_pkg::ST_STROBE) ||
                   (next_r.mode == card_host_pkg::MODE_DIRECT_ATA); // [RULE_09] [RULE_05]
      next_r.stat = decodeStatus(next_r.mode, r.s2, next_r.st == card_host_pkg::ST_IDLE);
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         r.st <= card_host_pkg::ST_RESET;
         r.mode <= card_host_pkg::MODE_MEMORY;
         r.cnt <= RESET_LAST;
         r.addr <= '0;
         r.data <= '0;
         r.attr <= 1'b0;
         r.softPhase <= 1'b0;
         r.resetActive <= 1'b1;
         r.done <= 1'b0;
         // card modes see a reset held since power-up as the power-up reset only
         r.resetPin <= 1'b1; // [RULE_02]
         r.ceN <= 1'b1;
         r.regN <= 1'b1;
         r.weN <= 1'b1;
         r.dataOeN <= 1'b1;
         r.s1 <= '0;
         r.s2 <= '0;
         r.stat <= '0;
      end else if (clkEn) begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign reqReady = (r.st == card_host_pkg::ST_IDLE); // [RULE_14]
   assign resetBusy = (r.st == card_host_pkg::ST_RESET) ||
                      (r.st == card_host_pkg::ST_READY_WAIT);
   assign wrDone = r.done;
   assign status = r.stat;
   assign cardResetPin = r.resetPin;
   assign cardCeN = r.ceN;
   assign cardRegN = r.regN;
   assign cardWeN = r.weN;
   assign cardAddr = r.addr;
   assign cardDataOut = r.data;
   assign cardDataOeN = r.dataOeN;

endmodule

// File: tb/card_host_port_monitor.sv
// port assertions for the card socket controller
`timescale 1ns/1ns
module card_host_port_monitor (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire card_host_pkg::mode_e mode,
   input wire logic hwResetReq,
   input wire logic reqReady,
   input wire logic wrDone,
   input wire logic resetBusy,
   input wire card_host_pkg::status_s status,
   input wire logic cardResetPin,
   input wire logic cardCeN,
   input wire logic cardRegN,
   input wire logic cardWeN,
   input wire logic cardDataOeN,
   input wire card_host_pkg::pin_in_s cardPins
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence strobeLow8; !cardWeN [*8]; endsequence
   // raw wait seen for four samples: the two sync flops have caught it by then
   sequence waitLow4; !cardPins.waitN [*4]; endsequence
   busy_no_take_a: assert property (resetBusy |-> !reqReady && cardCeN && cardWeN)
      else $error("access or request window open during reset");
   strobe_width_a: assert property ($fell(cardWeN) |-> strobeLow8)
      else $error("write strobe shorter than eight cycles");
   strobe_setup_a: assert property ($fell(cardWeN) |-> $past(cardCeN, 2) == 1'b0)
      else $error("strobe without address setup");
   wait_holds_a: assert property ((waitLow4 ##0 !cardWeN) |=> !cardWeN)
      else $error("strobe released while wait low");
   ata_no_strobe_a: assert property (mode == card_host_pkg::MODE_DIRECT_ATA
      |-> cardWeN) else $error("strobe pulsed in direct ata mode");
   io_config_only_a: assert property (mode == card_host_pkg::MODE_IO && !cardWeN
      |-> !cardRegN) else $error("common write in io mode");
   reset_high_a: assert property (hwResetReq && reqReady
      && mode != card_host_pkg::MODE_DIRECT_ATA |-> ##[1:2] cardResetPin)
      else $error("reset pin not high");
   reset_low_a: assert property (hwResetReq && reqReady
      && mode == card_host_pkg::MODE_DIRECT_ATA |-> ##[1:2] !cardResetPin)
      else $error("reset pin not low");
   sense_pins_a: assert property (status.cardReady
      |-> status.lowVoltCis && status.secondSenseOpen) else $error("voltage sense decode wrong");
   data_drive_a: assert property (!cardWeN |-> !cardDataOeN && !cardCeN)
      else $error("strobe low without data and enable driven");
   done_closes_a: assert property (wrDone |-> cardCeN && cardWeN && reqReady)
      else $error("done before cycle closed");
endmodule

// File: tb/card_device_model.sv
// behavioural model of the card behind the socket
`timescale 1ns/1ns
`include "card_host_defines.svh"
module card_device_model #(
   parameter int INIT_CYC = 20
) (
   input wire logic core_clk,
   input wire card_host_pkg::mode_e mode,
   input wire logic cardResetPin,
   input wire logic cardCeN,
   input wire logic cardRegN,
   input wire logic cardWeN,
   input wire logic [10:0] cardAddr,
   input wire logic [15:0] cardDataOut,
   input wire logic [7:0] stretch,
   output card_host_pkg::pin_in_s pins
);
   // power-up counts as one reset; a pin idle from power-up adds nothing
   int initCnt = INIT_CYC;
   int waitCnt = 0;
   int nWrites = 0;
   int nSoft = 0;
   logic [31:0] lastWrite = '0;
   logic weQ = 1'b1;
   wire ata = (mode == card_host_pkg::MODE_DIRECT_ATA);
   wire resetOn = ata ? !cardResetPin : cardResetPin;
   wire busy = (initCnt > 0) || resetOn;
   always @(posedge core_clk) begin
      weQ <= cardWeN;
      if (resetOn) initCnt <= INIT_CYC;
      else if (initCnt > 0) initCnt <= initCnt - 1;
      if (!cardWeN && weQ && !cardCeN && !ata) waitCnt <= int'(stretch);
      else if (waitCnt > 0) waitCnt <= waitCnt - 1;
      // trailing edge latches; ata ignores the strobe, io takes config only
      if (cardWeN && !weQ && !cardCeN && !ata &&
            (mode != card_host_pkg::MODE_IO || !cardRegN)) begin
         nWrites <= nWrites + 1;
         lastWrite <= {4'h0, cardRegN, cardAddr, cardDataOut};
         if (!cardRegN && cardAddr == `CONFIG_OPTION_ADDR &&
               cardDataOut[`SOFT_RESET_BIT]) begin
            nSoft <= nSoft + 1;
            initCnt <= INIT_CYC;
         end
      end
   end
   always_comb begin
      pins.rdy = !busy;
      pins.waitN = !(waitCnt > 0);
      pins.wpPin = busy;
      pins.vs1N = 1'b0;
      pins.vs2N = 1'b1;
   end
endmodule

// File: tb/tb.sv
// self-checking bench for the card socket controller
`timescale 1ns/1ns
module tb;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   card_host_pkg::mode_e mode = card_host_pkg::MODE_MEMORY;
   logic hwResetReq = 1'b0, softResetReq = 1'b0, wrReq = 1'b0, wrAttr = 1'b0;
   logic [10:0] wrAddr = '0, cardAddr;
   logic [15:0] wrData = '0, cardDataOut;
   logic [7:0] stretch = '0;
   logic clkEn = 1'b1;
   logic reqReady, wrDone, resetBusy, cardResetPin, cardCeN, cardRegN, cardWeN, cardDataOeN;
   card_host_pkg::status_s status;
   card_host_pkg::pin_in_s cardPins;
   int n_fail = 0;
   int compares = 0;
   logic [31:0] expQ[$];
   always #10 core_clk = ~core_clk;
   card_host_port card_host_port_i (.core_clk, .reset_n, .clkEn, .mode, .hwResetReq,
      .softResetReq, .wrReq, .wrAttr, .wrAddr, .wrData, .reqReady, .wrDone, .resetBusy, .status,
      .cardResetPin, .cardCeN, .cardRegN, .cardWeN, .cardAddr, .cardDataOut, .cardDataOeN,
      .cardPins);
   card_device_model card_device_model_i (.core_clk, .mode, .cardResetPin, .cardCeN, .cardRegN,
      .cardWeN, .cardAddr, .cardDataOut, .stretch, .pins(cardPins));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      if (n_fail == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // bounded wait for the request window, cycles counted from the taking edge
   task automatic settle(output int cyc);
      cyc = 1;
      @(negedge core_clk);
      while (!reqReady && cyc < 3000) begin
         cyc++;
         @(negedge core_clk);
      end
      if (!reqReady) begin
         n_fail++;
         close_out();
      end
   endtask
   task automatic issue(input int kind, input logic a, input logic [10:0] ad,
         input logic [15:0] d);
      int c;
      settle(c);
      @(posedge core_clk);
      #2;
      wrAttr = a;
      wrAddr = ad;
      wrData = d;
      wrReq = (kind == 0);
      softResetReq = (kind == 1);
      hwResetReq = (kind == 2);
      @(posedge core_clk);
      #2;
      {wrReq, softResetReq, hwResetReq} = 3'h0;
   endtask
   initial begin
      int m, k, cyc, n0, s0, lo;
      logic ok;
      logic [10:0] ad;
      logic [15:0] d;
      void'($urandom(50276));
      repeat (8) @(posedge core_clk);
      #2 reset_n = 1'b1;
      @(negedge core_clk);
      chk({cardResetPin, resetBusy, reqReady}, 3'h6);
      for (m = 0; m < 3; m++) begin
         settle(cyc);
         @(posedge core_clk);
         #2 mode = card_host_pkg::mode_e'(m);
         repeat (30) @(negedge core_clk);
         chk(status, {2'h2, m == 1, m == 2, 2'h3});
         for (k = 0; k < 4; k++) begin
            ad = 11'($urandom_range(0, 511));
            d = 16'($urandom);
            stretch = (k == 2) ? 8'h0C : 8'($urandom_range(0, 3));
            ok = (m == 0) || (m == 1 && k[0]);
            n0 = card_device_model_i.nWrites;
            if (ok) expQ.push_back({4'h0, !k[0], ad, d});
            issue(0, k[0], ad, d);
            if (k == 3) begin
               // enable held low across setup: the strobe must not start meanwhile
               clkEn = 1'b0;
               repeat (5) @(posedge core_clk);
               #2;
               chk({reqReady, cardCeN, cardWeN}, {!ok, !ok, 1'b1});
               clkEn = 1'b1;
            end
            settle(cyc);
            chk(wrDone, ok);
            chk(card_device_model_i.nWrites - n0, ok);
            if (ok) begin
               lo = (stretch > 8) ? 6 + stretch : 13;
               chk(card_device_model_i.lastWrite, expQ.pop_front());
               chk(cyc >= lo && cyc <= lo + 4, 1);
            end
         end
         s0 = card_device_model_i.nSoft;
         issue(1, 1'b0, 11'h000, 16'h0000);
         settle(cyc);
         chk(card_device_model_i.nSoft - s0, m != 2);
         issue(2, 1'b0, 11'h000, 16'h0000);
         repeat (3) @(negedge core_clk);
         chk({cardResetPin, cardPins.rdy}, {m != 2, 1'b0});
      end
      settle(cyc);
      close_out();
   end
endmodule
bind card_host_port card_host_port_monitor card_host_port_monitor_i (.core_clk, .reset_n, .mode,
   .hwResetReq, .reqReady, .wrDone, .resetBusy, .status, .cardResetPin, .cardCeN, .cardRegN,
   .cardWeN, .cardDataOeN, .cardPins);
